// File: src/cdsu_divide_shift_unit.sv
// Iterative divider and single-cycle barrel shifter of the core datapath
`timescale 1ns/1ns
`default_nettype none
module cdsu_divide_shift_unit
  import cdsu_pkg::*;
#(
  parameter int DATA_W = CDSU_DATA_W
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    divStart,
  input  wire logic [1:0]              divMode,
  input  wire logic [CDSU_IDX_W-1:0]   divisorSourceIdx,
  input  wire logic [CDSU_IDX_W-1:0]   dividendPairIdx,
  input  wire logic [DATA_W-1:0]       workRegFile [CDSU_REG_CNT],
  output logic                         divBusy,
  output logic                         divDone,
  output logic [DATA_W-1:0]            quotient_result_reg,
  output logic [DATA_W-1:0]            remainder_result_reg,
  input  wire logic                    shiftStart,
  input  wire logic [1:0]              shiftOp,
  input  wire logic [CDSU_SHAMT_W-1:0] shiftCount,
  input  wire logic [CDSU_IDX_W-1:0]   shiftSourceIdx,
  input  wire logic [CDSU_IDX_W-1:0]   shiftDestIdx,
  output logic                         shiftValid,
  output logic [CDSU_IDX_W-1:0]        shiftDestOut,
  output logic [DATA_W-1:0]            shiftResult
);

  function automatic logic [DATA_W-1:0] absVal(input logic [DATA_W-1:0] v);
    absVal = v[DATA_W-1] ? DATA_W'(-v) : v;
  endfunction

  cdsu_state_t            state_reg, state_next;
  logic [4:0]             cnt_reg, cnt_next;
  logic [2*DATA_W-1:0]    rem_reg, rem_next;
  logic [DATA_W-1:0]      dvs_reg, dvs_next;
  logic                   negQ_reg, negQ_next;
  logic                   negR_reg, negR_next;
  logic [DATA_W-1:0]      quo_next, remOut_next;
  logic                   done_next;
  logic [DATA_W-1:0]      hiWord, loWord, dvsIn;
  logic [2*DATA_W-1:0]    dividendMag;
  logic                   isSigned, isWide;
  logic [DATA_W:0]        trial;
  logic [2*DATA_W-1:0]    shifted;

  // Dividend from an even-aligned pair, upper half in the odd register for the 32-bit forms, sign or zero extended for the 16-bit forms
  always_comb begin
    isSigned = (divMode == CDSU_DIV_S32) || (divMode == CDSU_DIV_S16);
    isWide   = (divMode == CDSU_DIV_S32) || (divMode == CDSU_DIV_U32);
    loWord   = workRegFile[{dividendPairIdx[CDSU_IDX_W-1:1], 1'b0}];
    hiWord   = isWide ? workRegFile[{dividendPairIdx[CDSU_IDX_W-1:1], 1'b1}]
             : (isSigned ? {DATA_W{loWord[DATA_W-1]}} : CDSU_WORD_RESET);
    dvsIn    = workRegFile[divisorSourceIdx];
    if (isSigned && hiWord[DATA_W-1])
      dividendMag = (2*DATA_W)'(-{hiWord, loWord});
    else
      dividendMag = {hiWord, loWord};
  end

  // Restoring division, one divisor bit per cycle
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    rem_next    = rem_reg;
    dvs_next    = dvs_reg;
    negQ_next   = negQ_reg;
    negR_next   = negR_reg;
    quo_next    = quotient_result_reg;
    remOut_next = remainder_result_reg;
    done_next   = 1'b0;
    shifted     = {rem_reg[2*DATA_W-2:0], 1'b0};
    trial       = {1'b0, shifted[2*DATA_W-1:DATA_W]} - {1'b0, dvs_reg};
    unique case (state_reg)
      CDSU_IDLE: begin
        if (divStart) begin
          state_next = CDSU_BUSY;
          cnt_next   = 5'(CDSU_DIV_CYCLES);
          rem_next   = dividendMag;
          dvs_next   = isSigned ? absVal(dvsIn) : dvsIn;
          negQ_next  = isSigned && (hiWord[DATA_W-1] ^ dvsIn[DATA_W-1]);
          negR_next  = isSigned && hiWord[DATA_W-1];
        end
      end
      CDSU_BUSY: begin
        // Quotient bits shift into the low half, remainder in the high
        if (rem_reg[2*DATA_W-1] || !trial[DATA_W])
          rem_next = {trial[DATA_W-1:0], shifted[DATA_W-1:1], 1'b1};
        else
          rem_next = shifted;
        cnt_next = cnt_reg - 5'h01;
        if (cnt_reg == 5'h01) begin
          state_next  = CDSU_IDLE;
          done_next   = 1'b1;
          // Zero divisor gives all-ones quotient, 0x0001 for a negative signed dividend; no trap is raised here
          quo_next    = negQ_reg ? DATA_W'(-rem_next[DATA_W-1:0])
                                 : rem_next[DATA_W-1:0];
          remOut_next = negR_reg ? DATA_W'(-rem_next[2*DATA_W-1:DATA_W])
                                 : rem_next[2*DATA_W-1:DATA_W];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg            <= CDSU_IDLE;
      cnt_reg              <= CDSU_CNT_RESET;
      rem_reg              <= '0;
      dvs_reg              <= CDSU_WORD_RESET;
      negQ_reg             <= 1'b0;
      negR_reg             <= 1'b0;
      quotient_result_reg  <= CDSU_WORD_RESET;
      remainder_result_reg <= CDSU_WORD_RESET;
      divDone              <= 1'b0;
      divBusy              <= 1'b0;
    end else begin
      state_reg            <= state_next;
      cnt_reg              <= cnt_next;
      rem_reg              <= rem_next;
      dvs_reg              <= dvs_next;
      negQ_reg             <= negQ_next;
      negR_reg             <= negR_next;
      quotient_result_reg  <= quo_next;
      remainder_result_reg <= remOut_next;
      divDone              <= done_next;
      divBusy              <= (state_next == CDSU_BUSY);
    end
  end

  // Barrel shifter, register-direct source and destination only
  logic [DATA_W-1:0]     srcWord, shiftVal;
  logic                  shValid_next;
  logic [CDSU_IDX_W-1:0] shDest_next;

  always_comb begin
    srcWord = workRegFile[shiftSourceIdx];
    unique case (shiftOp)
      CDSU_ARITH_RIGHT_SHIFT_OP:
        shiftVal = DATA_W'($signed(srcWord) >>> shiftCount);
      CDSU_LEFT_SHIFT_OP:
        shiftVal = srcWord << shiftCount;
      CDSU_LOGICAL_RIGHT_SHIFT_OP:
        shiftVal = srcWord >> shiftCount;
      default:
        shiftVal = srcWord;
    endcase
    shValid_next = shiftStart && (shiftOp != 2'b11);
    shDest_next  = shiftDestIdx;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shiftValid   <= 1'b0;
      shiftDestOut <= '0;
      shiftResult  <= CDSU_WORD_RESET;
    end else begin
      shiftValid   <= shValid_next;
      shiftDestOut <= shDest_next;
      shiftResult  <= shiftVal;
    end
  end

  // Cycles since the last launch, cleared once the result is out
  int startGap_reg, startGap_next;

  always_comb begin
    if (state_reg == CDSU_IDLE && divStart)
      startGap_next = 1;
    else if (divDone)
      startGap_next = 0;
    else if (startGap_reg != 0)
      startGap_next = startGap_reg + 1;
    else
      startGap_next = startGap_reg;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      startGap_reg <= 0;
    else
      startGap_reg <= startGap_next;
  end

  sequence divLaunch;
    state_reg == CDSU_IDLE && divStart;
  endsequence

  sequence divRuns;
    divBusy [*8];
  endsequence

  AST_DIV_LATENCY: assert property (@(posedge clk_sys) disable iff (reset)
    divLaunch |-> ##17 divDone)
    else $error("divide did not finish in time");
  AST_DIV_BUSY_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    divLaunch |=> divRuns)
    else $error("busy dropped early");
  AST_DIV_NO_EARLY: assert property (@(posedge clk_sys) disable iff (reset)
    divLaunch |-> ##1 !divDone [*8])
    else $error("divide done too early");
  AST_DIV_RESULT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    divBusy && !divDone |-> $stable(quotient_result_reg))
    else $error("quotient changed while dividing");
  AST_DIV_REM_BOUND: assert property (@(posedge clk_sys) disable iff (reset)
    divDone && !negR_reg && dvs_reg != 16'h0000
      |-> remainder_result_reg < dvs_reg)
    else $error("remainder not below divisor");
  AST_SHL_ZERO_FILL: assert property (@(posedge clk_sys) disable iff (reset)
    shiftStart && shiftOp == CDSU_LEFT_SHIFT_OP && shiftCount == 4'hF
      |=> shiftResult[14:0] == 15'h0000)
    else $error("left shift did not zero fill");
  AST_ASR_SIGN_FILL: assert property (@(posedge clk_sys) disable iff (reset)
    shiftStart && shiftOp == CDSU_ARITH_RIGHT_SHIFT_OP
      && shiftCount == 4'hF
      |=> shiftResult == {16{$past(srcWord[15])}})
    else $error("arithmetic shift did not sign fill");
  AST_LSR_ZERO_TOP: assert property (@(posedge clk_sys) disable iff (reset)
    shiftStart && shiftOp == CDSU_LOGICAL_RIGHT_SHIFT_OP
      && shiftCount != 4'h0 |=> !shiftResult[15])
    else $error("logical shift top bit not zero");
  AST_SHIFT_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (reset)
    shiftStart && shiftOp != 2'b11 |=> shiftValid
      && shiftDestOut == $past(shiftDestIdx))
    else $error("shift result not ready next cycle");
  AST_GAP_BOUND: assert property (@(posedge clk_sys) disable iff (reset)
    startGap_reg <= CDSU_DIV_CYCLES + 1)
    else $error("divide ran past its cycle budget");

endmodule
`default_nettype wire

// File: src/cdsu_pkg.sv
// Constants and types shared by the divide and shift unit
package cdsu_pkg;
  localparam int CDSU_DATA_W  = 16;
  localparam int CDSU_REG_CNT = 16;
  localparam int CDSU_IDX_W   = 4;
  localparam int CDSU_SHAMT_W = 4;
  // One iteration per divisor bit, so every divide form takes this count
  localparam int CDSU_DIV_CYCLES = CDSU_DATA_W;
  localparam logic [4:0] CDSU_CNT_RESET = 5'h00;
  localparam logic [15:0] CDSU_WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CDSU_ARITH_RIGHT_SHIFT_OP   = 2'b00,
    CDSU_LEFT_SHIFT_OP          = 2'b01,
    CDSU_LOGICAL_RIGHT_SHIFT_OP = 2'b10
  } cdsu_shift_op_t;

  typedef enum logic [1:0] {
    CDSU_DIV_S32 = 2'b00,
    CDSU_DIV_U32 = 2'b01,
    CDSU_DIV_S16 = 2'b10,
    CDSU_DIV_U16 = 2'b11
  } cdsu_div_mode_t;

  typedef enum logic [0:0] {
    CDSU_IDLE = 1'b0,
    CDSU_BUSY = 1'b1
  } cdsu_state_t;
endpackage

// File: verification/cdsu_core_model.sv
// Working register file of the core, feeding the unit's operand port
`timescale 1ns/1ns
`default_nettype none
module cdsu_core_model
  import cdsu_pkg::*;
(
  output logic [CDSU_DATA_W-1:0] workRegFile [CDSU_REG_CNT]
);
  logic [CDSU_DATA_W-1:0] regs [CDSU_REG_CNT];
  // Unloaded registers hold a pattern, so stray reads show up
  initial begin
    for (int i = 0; i < CDSU_REG_CNT; i++) begin
      regs[i] = 16'hA5C3 ^ 16'(i);
    end
  end
  task automatic load(input int idx, input logic [15:0] val);
    regs[idx] = val;
  endtask
  assign workRegFile = regs;
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the divide and shift unit
`timescale 1ns/1ns
`default_nettype none
module testbench
  import cdsu_pkg::*;
;
  logic        clk_sys, reset, divStart, divBusy, divDone;
  logic [1:0]  divMode, shiftOp;
  logic [3:0]  divisorSourceIdx, dividendPairIdx, shiftCount;
  logic [3:0]  shiftSourceIdx, shiftDestIdx, shiftDestOut;
  logic [15:0] quot, remd, shiftResult;
  logic [15:0] workRegFile [CDSU_REG_CNT];
  logic        shiftStart, shiftValid;
  int          fails, samplesChecked;
  cdsu_core_model model (.workRegFile(workRegFile));
  cdsu_divide_shift_unit dut (
    .clk_sys(clk_sys), .reset(reset), .divStart(divStart),
    .divMode(divMode), .divisorSourceIdx(divisorSourceIdx),
    .dividendPairIdx(dividendPairIdx), .workRegFile(workRegFile),
    .divBusy(divBusy), .divDone(divDone), .quotient_result_reg(quot),
    .remainder_result_reg(remd), .shiftStart(shiftStart),
    .shiftOp(shiftOp), .shiftCount(shiftCount),
    .shiftSourceIdx(shiftSourceIdx), .shiftDestIdx(shiftDestIdx),
    .shiftValid(shiftValid), .shiftDestOut(shiftDestOut),
    .shiftResult(shiftResult));
  task automatic check(input string what, input logic [15:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Dividend pair given by its odd index, bit0 must be ignored
  task automatic run_div(input logic [1:0] mode, input logic [31:0] dvd,
                         input logic [15:0] dvs, input logic [3:0] dsIdx);
    longint a, b;
    int     cnt;
    a = mode[0] ? (mode[1] ? longint'(dvd[15:0]) : longint'(dvd))
                : (mode[1] ? longint'($signed(dvd[15:0]))
                           : longint'($signed(dvd)));
    b = mode[0] ? longint'(dvs) : longint'($signed(dvs));
    model.load(4, dvd[15:0]);
    model.load(5, dvd[31:16]);
    model.load(dsIdx, dvs);
    divMode = mode;
    divisorSourceIdx = dsIdx;
    dividendPairIdx = 4'h5;
    divStart = 1'b1;
    @(negedge clk_sys);
    divStart = 1'b0;
    cnt = 0;
    while (divDone !== 1'b1 && cnt < 40) begin
      @(negedge clk_sys);
      cnt++;
      // A start while busy must be ignored
      divStart = (cnt == 4);
      if (cnt == 8) check("div busy", 16'(divBusy), 16'h0001);
    end
    check("div cycles", 16'(cnt), 16'(CDSU_DIV_CYCLES));
    check("div busy end", 16'(divBusy), 16'h0000);
    check("quotient", quot, 16'(a / b));
    check("remainder", remd, 16'(a % b));
  endtask
  // Leaves shiftStart high so calls run back to back
  task automatic run_shift(input logic [1:0] op, input logic [3:0] amt,
                           input logic [15:0] src, input logic [3:0] dst);
    logic [15:0] exp;
    model.load(3, src);
    shiftStart = 1'b1;
    shiftOp = op;
    shiftCount = amt;
    shiftSourceIdx = 4'h3;
    shiftDestIdx = dst;
    case (op)
      CDSU_ARITH_RIGHT_SHIFT_OP: exp = $signed(src) >>> amt;
      CDSU_LEFT_SHIFT_OP:        exp = src << amt;
      default:                   exp = src >> amt;
    endcase
    @(negedge clk_sys);
    check("shift valid", 16'(shiftValid), 16'h0001);
    check("shift result", shiftResult, exp);
    check("shift dest", 16'(shiftDestOut), 16'(dst));
  endtask
  task automatic test_divide;
    run_div(CDSU_DIV_S32, 32'hFFF0_BD9B, 16'h0064, 4'h9);
    run_div(CDSU_DIV_U32, 32'hFFFE_0001, 16'hFFFF, 4'h0);
    run_div(CDSU_DIV_S16, 32'h1234_8001, 16'hFFF6, 4'hF);
    run_div(CDSU_DIV_U16, 32'hABCD_FFFF, 16'h0010, 4'h2);
  endtask
  task automatic test_shift;
    logic [3:0] amts [3];
    amts = '{4'h1, 4'hF, 4'h6};
    for (int op = 0; op < 3; op++) begin
      foreach (amts[k]) begin
        run_shift(2'(op), amts[k], k == 1 ? 16'h7A31 : 16'hB2C5, 4'(op * 3 + k));
      end
    end
    shiftOp = 2'b11;
    @(negedge clk_sys);
    check("illegal op valid", 16'(shiftValid), 16'h0000);
    shiftStart = 1'b0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial begin
    {divStart, divMode, divisorSourceIdx, dividendPairIdx} = '0;
    {shiftStart, shiftOp, shiftCount, shiftSourceIdx, shiftDestIdx} = '0;
    fails = 0;
    samplesChecked = 0;
    reset = 1'b1;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    test_divide();
    test_shift();
    report_and_stop();
  end
endmodule
`default_nettype wire
